/* rtl/srw_top.v */
// Purpose: Supervisor reset generator with watchdog and supply monitor
// Assumes: clk is the free-running internal oscillator; pins are async
// Notes: Reset pin is open drain; polarity chosen by ACTIVE_HIGH
`timescale 1ns/10ps
`include "srw_defs.vh"
module srw_top
#(
  parameter ACTIVE_HIGH = 1'b0,
  parameter TICK_CYCLES = `SRW_TICK_NS / `SRW_CLK_PERIOD_NS
)
(
  input wire clk,
  input wire reset_n,
  input wire supply_low,
  input wire sda_in,
  input wire scl_in,
  input wire wp_pin,
  input wire [2:0] nv_cfg,
  input wire ctrl_wr,
  input wire [7:0] ctrl_wdata,
  output wire reset_pin_out,
  output wire reset_pin_oe,
  output reg ctrl_wr_done,
  output reg ctrl_wr_rejected,
  output reg [2:0] nv_store_data,
  output reg nv_store,
  output reg xfer_abort,
  output wire xfer_allow,
  output wire [1:0] timeout_select,
  output wire protect_pin_enable_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_LOW = 3'h1;
  localparam [2:0] ST_HOLD = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;
  localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
  localparam [`SRW_TICK_W-1:0] TICK_LAST = TICK_LAST_FULL[`SRW_TICK_W-1:0];

  // ----------------------------------------
  // Timeout decode
  // ----------------------------------------
  function [`SRW_MS_W-1:0] timeout_ms;
    input [1:0] sel;
    begin
      case (sel)
        `SRW_SEL_LONG: timeout_ms = `SRW_WD_LONG_MS;
        `SRW_SEL_MID: timeout_ms = `SRW_WD_MID_MS;
        `SRW_SEL_SHORT: timeout_ms = `SRW_WD_SHORT_MS;
        default: timeout_ms = `SRW_WD_LONG_MS;
      endcase
    end
  endfunction

  wire supply_low_s;
  wire sda_s;
  wire scl_s;
  wire wp_s;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [`SRW_TICK_W-1:0] prescale;
  reg [`SRW_MS_W-1:0] ms_count;
  reg sda_prev;
  reg cfg_loaded;
  reg protect_en;
  reg sel_hi;
  reg sel_lo;
  wire tick;
  wire kick;
  wire wd_enabled;
  wire wd_expired;
  wire hold_done;
  wire reset_active;
  wire write_blocked;
  reg restart_count;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  srw_sync #(.RESET_VALUE(1'b1)) u_sync_supply (
    .clk(clk), .reset_n(reset_n), .din(supply_low), .dout(supply_low_s));
  srw_sync #(.RESET_VALUE(1'b1)) u_sync_sda (
    .clk(clk), .reset_n(reset_n), .din(sda_in), .dout(sda_s));
  srw_sync #(.RESET_VALUE(1'b1)) u_sync_scl (
    .clk(clk), .reset_n(reset_n), .din(scl_in), .dout(scl_s));
  srw_sync #(.RESET_VALUE(1'b1)) u_sync_wp (
    .clk(clk), .reset_n(reset_n), .din(wp_pin), .dout(wp_s));

  // ----------------------------------------
  // Start detect and timing
  // ----------------------------------------
  assign kick = sda_prev & ~sda_s & scl_s;
  assign tick = (prescale == TICK_LAST);
  assign timeout_select = {sel_hi, sel_lo};
  assign wd_enabled = (timeout_select != `SRW_SEL_OFF);
  assign wd_expired = wd_enabled && (ms_count >= timeout_ms(timeout_select));
  assign hold_done = (ms_count == `SRW_HOLD_MS);

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_prev <= 1'b1;
    end
    else
    begin
      sda_prev <= sda_s;
    end
  end

  // ----------------------------------------
  // Supervisor state machine
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    restart_count = 1'b0;
    case (state)
      ST_LOW:
      begin
        restart_count = 1'b1;
        if (!supply_low_s)
        begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (supply_low_s)
        begin
          next_state = ST_LOW;
          restart_count = 1'b1;
        end
        else if (hold_done)
        begin
          next_state = ST_RUN;
          restart_count = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (supply_low_s)
        begin
          next_state = ST_LOW;
          restart_count = 1'b1;
        end
        else if (wd_expired)
        begin
          next_state = ST_HOLD;
          restart_count = 1'b1;
        end
        else if (kick || !wd_enabled)
        begin
          restart_count = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_LOW;
        restart_count = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_LOW;
      prescale <= {`SRW_TICK_W{1'b0}};
      ms_count <= {`SRW_MS_W{1'b0}};
    end
    else
    begin
      state <= next_state;
      if (restart_count || tick)
      begin
        prescale <= {`SRW_TICK_W{1'b0}};
      end
      else
      begin
        prescale <= prescale + 1'b1;
      end
      if (restart_count)
      begin
        ms_count <= {`SRW_MS_W{1'b0}};
      end
      else if (tick)
      begin
        ms_count <= ms_count + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Reset pin and transfer gating
  // ----------------------------------------
  assign reset_active = (state != ST_RUN);
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = ACTIVE_HIGH ? ~reset_active : reset_active;
  assign xfer_allow = ~reset_active;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xfer_abort <= 1'b0;
    end
    else
    begin
      xfer_abort <= (state == ST_RUN) && (next_state != ST_RUN);
    end
  end

  // ----------------------------------------
  // Control bits, nonvolatile copy
  // ----------------------------------------
  assign protect_pin_enable_q = protect_en;
  assign write_blocked = (wp_s && protect_en) || reset_active;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_loaded <= 1'b0;
      {protect_en, sel_hi, sel_lo} <= `SRW_NV_RESET;
      ctrl_wr_done <= 1'b0;
      ctrl_wr_rejected <= 1'b0;
      nv_store <= 1'b0;
      nv_store_data <= `SRW_NV_RESET;
    end
    else
    begin
      ctrl_wr_done <= 1'b0;
      ctrl_wr_rejected <= 1'b0;
      nv_store <= 1'b0;
      if (!cfg_loaded)
      begin
        cfg_loaded <= 1'b1;
        {protect_en, sel_hi, sel_lo} <= nv_cfg;
      end
      else if (ctrl_wr)
      begin
        if (write_blocked)
        begin
          ctrl_wr_rejected <= 1'b1;
        end
        else
        begin
          protect_en <= ctrl_wdata[`SRW_BIT_PROTECT_EN];
          sel_hi <= ctrl_wdata[`SRW_BIT_SEL_HI];
          sel_lo <= ctrl_wdata[`SRW_BIT_SEL_LO];
          nv_store_data <= {ctrl_wdata[`SRW_BIT_PROTECT_EN],
                            ctrl_wdata[`SRW_BIT_SEL_HI],
                            ctrl_wdata[`SRW_BIT_SEL_LO]};
          nv_store <= 1'b1;
          ctrl_wr_done <= 1'b1;
        end
      end
    end
  end

endmodule // srw_top

/* rtl/srw_defs.vh */
// Purpose: Shared constants for the supervisor reset watchdog
// Assumes: 40 MHz internal oscillator drives clk
// Notes: Times in their own units, cycle counts derived from them
`ifndef SRW_DEFS_VH
`define SRW_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRW_CLK_PERIOD_NS 25
`define SRW_TICK_NS 1000000
`define SRW_HOLD_MS 11'h0fa
`define SRW_WD_LONG_MS 11'h578
`define SRW_WD_MID_MS 11'h258
`define SRW_WD_SHORT_MS 11'h0c8
`define SRW_MS_W 11
`define SRW_TICK_W 24

// ----------------------------------------
// Control byte fields
// ----------------------------------------
`define SRW_BIT_PROTECT_EN 7
`define SRW_BIT_SEL_HI 6
`define SRW_BIT_SEL_LO 5
`define SRW_SEL_LONG 2'h0
`define SRW_SEL_MID 2'h1
`define SRW_SEL_SHORT 2'h2
`define SRW_SEL_OFF 2'h3
`define SRW_NV_RESET 3'h0

`endif

/* rtl/srw_sync.v */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes: Output changes once stages two and three agree
`timescale 1ns/10ps
module srw_sync
#(
  parameter RESET_VALUE = 1'b1
)
(
  input wire clk,
  input wire reset_n,
  input wire din,
  output reg dout
);

  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      dout <= RESET_VALUE;
    end
    else
    begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
      begin
        dout <= stage3;
      end
    end
  end

endmodule // srw_sync

/* verification/srw_host.sv */
// Purpose: Host model for watchdog restarts
// Assumes: Lines idle high through pull-ups
// Notes: A kick gives one start then a stop
`timescale 1ns/10ps
module srw_host
(
  input wire clk,
  input wire kick,
  output reg sda = 1'b1,
  output reg scl = 1'b1
);
  always @(posedge clk)
    if (kick)
    begin
      sda <= 1'b0;
      repeat (3) @(posedge clk);
      sda <= 1'b1;
    end
endmodule // srw_host

/* verification/srw_sva.sv */
// Purpose: Port checker for srw_top
// Assumes: One clock, async low reset
// Notes: Counters time supply-good runs and idling
`timescale 1ns/10ps
module srw_sva
#(
  parameter ACTIVE_HIGH = 1'b0,
  parameter TICK_CYCLES = 4
)
(
  input wire clk,
  input wire reset_n,
  input wire supply_low,
  input wire sda_in,
  input wire scl_in,
  input wire wp_pin,
  input wire ctrl_wr,
  input wire [7:0] ctrl_wdata,
  input wire reset_pin_out,
  input wire reset_pin_oe,
  input wire ctrl_wr_rejected,
  input wire nv_store,
  input wire ctrl_wr_done,
  input wire xfer_abort,
  input wire xfer_allow,
  input wire [1:0] timeout_select,
  input wire protect_pin_enable_q
);
  localparam int HOLD = 250 * TICK_CYCLES;
  localparam int WD_MAX = 200 * TICK_CYCLES + 12;
  logic [15:0] good;
  logic [15:0] idle;
  logic sda_q;
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      good <= 16'h0;
      idle <= 16'h0;
      sda_q <= 1'b1;
    end
    else
    begin
      sda_q <= sda_in;
      good <= supply_low ? 16'h0 : good + {15'h0, good != 16'hffff};
      idle <= (!xfer_allow || (sda_q && !sda_in && scl_in)) ? 16'h0 : idle + 16'h1;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence abort_s;
    xfer_abort ##1 !xfer_abort;
  endsequence
  sequence prot_wr_s;
    wp_pin [*6] ##0 (ctrl_wr && protect_pin_enable_q);
  endsequence
  pin_drive_a: assert property (!reset_pin_out && reset_pin_oe == (xfer_allow ^ !ACTIVE_HIGH))
    else $error("reset pin drive wrong");
  supply_forces_a: assert property (supply_low [*6] |-> !xfer_allow)
    else $error("no reset on low supply");
  hold_time_a: assert property ($rose(xfer_allow) |-> good >= HOLD)
    else $error("reset released early");
  abort_pulse_a: assert property ($fell(xfer_allow) |-> abort_s)
    else $error("abort pulse wrong");
  wd_bound_a: assert property (timeout_select == 2'h2 |-> idle <= WD_MAX)
    else $error("watchdog late");
  protect_refuse_a: assert property (prot_wr_s |=> ctrl_wr_rejected && !nv_store)
    else $error("protected write taken");
  write_update_a: assert property (ctrl_wr_done |-> nv_store && timeout_select == $past(ctrl_wdata[6:5]))
    else $error("write not applied");
  reset_refuse_a: assert property (ctrl_wr && !xfer_allow |=> ctrl_wr_rejected)
    else $error("write taken in reset");
endmodule // srw_sva
bind srw_top srw_sva #(.ACTIVE_HIGH(ACTIVE_HIGH), .TICK_CYCLES(TICK_CYCLES)) i_sva (.clk(clk),
  .reset_n(reset_n), .supply_low(supply_low), .sda_in(sda_in), .scl_in(scl_in), .wp_pin(wp_pin),
  .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .ctrl_wr_rejected(ctrl_wr_rejected), .nv_store(nv_store),
  .ctrl_wr_done(ctrl_wr_done), .xfer_abort(xfer_abort), .xfer_allow(xfer_allow),
  .timeout_select(timeout_select), .protect_pin_enable_q(protect_pin_enable_q));

/* verification/tb_supervisor_reset_watchdog.sv */
// Purpose: Self-checking bench for srw_top
// Assumes: TICK_CYCLES shortened to 4
// Notes: Times checked as cycle windows
`timescale 1ns/10ps
module tb_supervisor_reset_watchdog;
  localparam int T = 4;
  logic clk = 0, reset_n = 0, supply_low = 0, wp_pin = 0, ctrl_wr = 0, kick = 0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic [2:0] nv_mem = 3'h0;
  wire sda, scl, rp_out, rp_oe, wdone, wrej, nvst, abort, allow, pe;
  wire [2:0] nvd;
  wire [1:0] tsel;
  int errors = 0, cmp_count = 0, cyc = 0, n;
  always #12.5 clk = ~clk;
  srw_top #(.TICK_CYCLES(T)) i_dut (.clk(clk), .reset_n(reset_n), .supply_low(supply_low),
    .sda_in(sda), .scl_in(scl), .wp_pin(wp_pin), .nv_cfg(nv_mem), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .reset_pin_out(rp_out), .reset_pin_oe(rp_oe), .ctrl_wr_done(wdone),
    .ctrl_wr_rejected(wrej), .nv_store_data(nvd), .nv_store(nvst), .xfer_abort(abort),
    .xfer_allow(allow), .timeout_select(tsel), .protect_pin_enable_q(pe));
  srw_host i_host (.clk(clk), .kick(kick), .sda(sda), .scl(scl));
  // Nonvolatile copy kept across power cycles
  always @(posedge clk)
  begin
    if (nvst)
      nv_mem <= nvd;
  end
  task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic span(input logic lvl, input int lo, input int hi);
    n = 0;
    while (allow !== lvl && n < 9000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("span", 16'h1, 16'(n >= lo && n <= hi));
    if (!lvl)
    begin
      check("abort", 16'h1, 16'(abort));
      span(1'b1, 250 * T - 2, 250 * T + 16);
    end
  endtask
  task wr(input logic [7:0] d, input logic ok);
    @(posedge clk);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= d;
    @(posedge clk);
    ctrl_wr <= 1'b0;
    #1;
    check("done", 16'(ok), 16'(wdone));
    check("store", 16'(ok), 16'(nvst));
    check("reject", 16'(!ok), 16'(wrej));
  endtask
  task t_power;
    @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check("oe", 16'h1, 16'(rp_oe));
    span(1'b1, 250 * T, 250 * T + 16);
    check("pin", 16'h0, {14'h0, rp_out, rp_oe});
    span(1'b0, 1400 * T - 2, 1400 * T + 12);
  endtask
  task t_select;
    wr(8'h20, 1'b1);
    check("sel", 16'h0101, {5'h0, nvd, 6'h0, tsel});
    span(1'b0, 600 * T - 2, 600 * T + 12);
    wr(8'hc0, 1'b1);
    @(posedge clk);
    wp_pin <= 1'b1;
    repeat (8) @(posedge clk);
    wr(8'h20, 1'b0);
    check("keep", 16'h0012, {11'h0, pe, 2'h0, tsel});
    @(posedge clk);
    wp_pin <= 1'b0;
    repeat (8) @(posedge clk);
    wr(8'hc0, 1'b1);
  endtask
  task t_kick;
    repeat (6)
    begin
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      repeat (600) @(posedge clk);
      #1;
      check("alive", 16'h1, 16'(allow));
    end
    span(1'b0, 200 * T - 610, 200 * T - 590);
  endtask
  task t_supply;
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("low", 16'h0, 16'(allow));
    wr(8'h20, 1'b0);
    @(posedge clk);
    supply_low <= 1'b0;
    span(1'b1, 250 * T, 250 * T + 16);
  endtask
  task t_recall;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("rst", 16'h0001, {14'h0, allow, rp_oe});
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("recall", 16'h0012, {11'h0, pe, 2'h0, tsel});
    span(1'b1, 250 * T, 250 * T + 16);
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    t_power();
    t_select();
    t_kick();
    t_supply();
    t_recall();
    conclude();
  end
endmodule // tb_supervisor_reset_watchdog
